/* File: common/staircase_pkg.sv */
// Constants for the staircase code sequencer.
// Assumes a single 125 MHz system clock.
package staircase_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned OSC_HZ = 1000000;
	// System clocks per reference oscillator period.
	localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
	localparam int unsigned RATE_W = 3;
	localparam int unsigned CODE_W = 4;
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic [3:0] COUNT_SELECT = 4'hA;
	localparam logic [3:0] COUNT_LAST = 4'hE;
	localparam logic [3:0] CODE_HOLD = 4'h5;
	localparam logic [7:0] LEAD_RESET = 8'h04;
endpackage : staircase_pkg

/* File: rtl/staircase_code_sequencer.sv */
// Staircase code sequencer: step clock divider, counter, hold select, mux.
// Assumes the rate selection and lead delay are quasi-static pins.
`timescale 1ns/1ps
module staircase_code_sequencer #(
	parameter int unsigned RATE_W = staircase_pkg::RATE_W,
	parameter int unsigned LEAD_W = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Controls from pins.
	input wire logic [RATE_W-1:0] rate_sel,
	input wire logic [LEAD_W-1:0] lead_delay,
	// Outputs.
	output logic pretrig,
	output logic step_clk,
	output logic [3:0] dac_code
);
	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers.
	logic [1:0] rst_sync_q;
	logic [1:0] rst_sync_d;
	logic rst_in_n;
	always_comb rst_sync_d = {rst_sync_q[0], 1'b1};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= rst_sync_d;
		end
	end
	assign rst_in_n = rst_sync_q[1];

	logic [RATE_W-1:0] rate_q;
	logic [LEAD_W-1:0] lead_q;
	pin_sync #(
		.W(RATE_W)
	) rate_sync_u (
		.clk(clk),
		.rst_in_n(rst_in_n),
		.pin(rate_sel),
		.value(rate_q)
	);
	pin_sync #(
		.W(LEAD_W),
		.RST_VAL(LEAD_W'(staircase_pkg::LEAD_RESET))
	) lead_sync_u (
		.clk(clk),
		.rst_in_n(rst_in_n),
		.pin(lead_delay),
		.value(lead_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Reference oscillator tick and divided step clock.
	localparam int unsigned OSC_W = $clog2(staircase_pkg::OSC_DIV_CYC);
	localparam int unsigned DIV_W = (1 << RATE_W) + 1;
	logic [OSC_W-1:0] osc_q, osc_d;
	logic [DIV_W-1:0] div_q, div_d, div_last;
	logic osc_tick, div_tick;
	assign osc_tick = (osc_q == OSC_W'(staircase_pkg::OSC_DIV_CYC - 1));
	// Division ratio is two to the power of the rate selection.
	assign div_last = DIV_W'((DIV_W'(1) << rate_q) - DIV_W'(1));
	assign div_tick = osc_tick && (div_q >= div_last);
	always_comb begin
		osc_d = osc_tick ? '0 : OSC_W'(osc_q + 1'b1);
		div_d = div_q;
		if (osc_tick) begin
			div_d = div_tick ? '0 : DIV_W'(div_q + 1'b1);
		end
	end
	always_ff @(posedge clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			osc_q <= '0;
			div_q <= '0;
		end else begin
			osc_q <= osc_d;
			div_q <= div_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pretrigger pulse and delayed step pulse.
	logic [LEAD_W:0] lead_cnt_q, lead_cnt_d;
	logic lead_busy_q, lead_busy_d;
	logic pretrig_q, pretrig_d;
	logic step_q, step_d;
	always_comb begin
		lead_cnt_d = lead_cnt_q;
		lead_busy_d = lead_busy_q;
		step_d = 1'b0;
		pretrig_d = div_tick;
		if (div_tick) begin
			lead_busy_d = 1'b1;
			lead_cnt_d = '0;
		end else if (lead_busy_q) begin
			if (lead_cnt_q >= {1'b0, lead_q}) begin
				lead_busy_d = 1'b0;
				step_d = 1'b1;
			end else begin
				lead_cnt_d = (LEAD_W+1)'(lead_cnt_q + 1'b1);
			end
		end
	end
	always_ff @(posedge clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			lead_cnt_q <= '0;
			lead_busy_q <= 1'b0;
			pretrig_q <= 1'b0;
			step_q <= 1'b0;
		end else begin
			lead_cnt_q <= lead_cnt_d;
			lead_busy_q <= lead_busy_d;
			pretrig_q <= pretrig_d;
			step_q <= step_d;
		end
	end
	assign pretrig = pretrig_q;
	assign step_clk = step_q;

	////////////////////////////////////////////////////////////////////////
	// Step counter, hold select and code multiplexer.
	logic [3:0] count_q;
	logic [3:0] count_d;
	logic [3:0] count_next;
	logic [3:0] code_q;
	logic [3:0] code_d;
	logic select_q;
	logic select_d;
	logic count_bit0, count_bit1, count_bit2, count_bit3;
	assign count_next = 4'(count_q + 4'h1);
	assign count_bit0 = count_next[3];
	assign count_bit1 = count_next[2];
	assign count_bit2 = count_next[1];
	assign count_bit3 = count_next[0];
	always_comb begin
		count_d = count_q;
		select_d = select_q;
		code_d = code_q;
		if (step_q) begin
			if (count_q == staircase_pkg::COUNT_LAST) begin
				count_d = staircase_pkg::CODE_RESET;
				select_d = 1'b0;
			end else begin
				count_d = count_next;
				if ({count_bit0, count_bit1, count_bit2, count_bit3}
					== staircase_pkg::COUNT_SELECT) begin
					select_d = 1'b1;
				end
			end
			// Counts 10 to 14 show the hold level: five intervals.
			code_d = select_d ? staircase_pkg::CODE_HOLD
				: count_d;
		end
	end
	always_ff @(posedge clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			count_q <= staircase_pkg::CODE_RESET;
			select_q <= 1'b0;
			code_q <= staircase_pkg::CODE_RESET;
		end else begin
			count_q <= count_d;
			select_q <= select_d;
			code_q <= code_d;
		end
	end
	assign dac_code = code_q;
endmodule : staircase_code_sequencer

////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser.
// A new pin value is taken once stages two and three agree.
module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_in_n,
	// Pin and settled value.
	input wire logic [W-1:0] pin,
	output logic [W-1:0] value
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_q;
	logic [W-1:0] s2_d;
	logic [W-1:0] s3_q;
	logic [W-1:0] s3_d;
	logic [W-1:0] value_q;
	logic [W-1:0] value_d;
	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
		s3_d = s2_q;
		value_d = value_q;
		if (s2_q == s3_q) begin
			value_d = s3_q;
		end
	end
	always_ff @(posedge clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			value_q <= RST_VAL;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			value_q <= value_d;
		end
	end
	assign value = value_q;
endmodule : pin_sync

/* File: bench/dac_model.sv */
// Converter model: turns the code into a staircase level.
// Assumes one clock and a code that is stable between steps.
`timescale 1ns/1ps
module dac_model (
	input wire logic clk,
	input wire logic [3:0] code,
	output int level
);
	always_ff @(posedge clk) level <= int'(code);
endmodule : dac_model

/* File: bench/staircase_checker.sv */
// Checker for the staircase sequencer ports.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ps
module staircase_checker #(
	parameter int unsigned RATE_W = 3,
	parameter int unsigned LEAD_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [RATE_W-1:0] rate_sel,
	input wire logic [LEAD_W-1:0] lead_delay,
	input wire logic pretrig,
	input wire logic step_clk,
	input wire logic [3:0] dac_code
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (step_clk) begin
			cnt_d = (cnt_q == staircase_pkg::COUNT_LAST) ? 4'h0
				: 4'(cnt_q + 4'h1);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 4'h0;
		else cnt_q <= cnt_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_step9; step_clk && cnt_q == 4'h9; endsequence
	sequence s_hold; (dac_code == 4'h5) [*6]; endsequence
	a_pre_gap: assert property (pretrig |=> !pretrig [*8])
		else $error("pretrig too close");
	a_step_single: assert property (step_clk |=> !step_clk)
		else $error("step too long");
	a_step_lead: assert property (pretrig |-> ##[1:256] step_clk)
		else $error("step missing");
	a_step_apart: assert property (step_clk |-> !pretrig)
		else $error("step on pretrig");
	a_code_moves: assert property ($changed(dac_code)
		|-> $past(step_clk)) else $error("code off step");
	a_code_seq: assert property ($past(step_clk) |->
		dac_code == ((cnt_q >= 4'hA) ? 4'h5 : cnt_q)) else $error("bad code");
	a_select_hold: assert property (s_step9 |=> s_hold)
		else $error("no hold");
	a_wrap_zero: assert property (step_clk
		&& cnt_q == staircase_pkg::COUNT_LAST |=> dac_code == 4'h0)
		else $error("no wrap");
endmodule : staircase_checker
bind staircase_code_sequencer staircase_checker #(.RATE_W(RATE_W),
	.LEAD_W(LEAD_W)) chk_u (.clk(clk), .rst_n(rst_n), .rate_sel(rate_sel),
	.lead_delay(lead_delay), .pretrig(pretrig), .step_clk(step_clk),
	.dac_code(dac_code));

/* File: bench/tb.sv */
// Self-checking bench for the staircase sequencer.
// Assumes the sequencer, checker and converter model are compiled first.
`timescale 1ns/1ps
module tb;
	logic clk, rst_n, pretrig, step_clk;
	logic [2:0] rate_sel;
	logic [7:0] lead_delay;
	logic [3:0] dac_code, cnt;
	logic [15:0] rnd;
	int fails, checks, c, level;
	staircase_code_sequencer dut_u (.clk(clk), .rst_n(rst_n),
		.rate_sel(rate_sel), .lead_delay(lead_delay), .pretrig(pretrig),
		.step_clk(step_clk), .dac_code(dac_code));
	dac_model dac_u (.clk(clk), .code(dac_code), .level(level));
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [3:0] exp_code(logic [3:0] n);
		return (n >= 4'hA) ? 4'h5 : n;
	endfunction : exp_code
	task automatic check(logic [31:0] seen, logic [31:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: %h vs %h", $time, seen, want);
		end
	endtask : check
	task automatic stop_test();
		$display("fails %0d checks %0d", fails, checks);
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	task automatic wait_for(logic step);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while ((step ? step_clk : pretrig) !== 1'b1 && c < 2000);
		if ((step ? step_clk : pretrig) !== 1'b1) fails++;
	endtask : wait_for
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		#400000 fails++;
		stop_test();
	end
	always @(negedge clk) if (step_clk === 1'b1) begin
		cnt = (cnt == staircase_pkg::COUNT_LAST) ? 4'h0 : cnt + 4'h1;
		@(posedge clk);
		#1 check(dac_code, exp_code(cnt));
		@(posedge clk);
		#1 check(level, exp_code(cnt));
	end
	initial begin
		rst_n = 0;
		rate_sel = 3'h0;
		lead_delay = 8'h00;
		cnt = 4'h0;
		rnd = 16'hA67B;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			@(posedge clk);
			#1 rate_sel = (i == 1) ? 3'h2 : {1'b0, rnd[1:0]};
			lead_delay = (i == 1) ? 8'hFF : (i == 0) ? 8'h00 : {2'h0, rnd[13:8]};
			repeat (3) wait_for(1'b0);
			wait_for(1'b1);
			check(c, lead_delay + 1);
			wait_for(1'b0);
			check(c + lead_delay + 1, staircase_pkg::OSC_DIV_CYC << rate_sel);
		end
		stop_test();
	end
endmodule : tb
